/* File: core/pdmc_top.sv */
// Function
// - Sleep instruction enters sleep/subsleep when standby bit is 0, standby/watch when 1.
// - Three-bit standby timer in bits 6..4 sets wake wait after an interrupt ends standby or watch.
// - A non-recommended setting is honoured as programmed, possibly ending early.
// - Leaving watch mode, CPU resumes on subclock if bit 3 set, else system clock.
// - Bit 2 is reserved: always reads 1, writes ignored.
// - After reset control bits read 0 and reserved bit 2 reads 1.
// - Timer codes map to 8192,16384,1024,2048,4096,2,8,16; variant uses 32768..131072.
// - Bits 1..0 pick medium clock divider 16/32/64/128, reset to 11.
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pdmc_cfg.svh"
module pdmc_top
  import pdmc_pkg::*;
#(
  parameter bit ONCHIP_OSC_VARIANT = 1'b0,  // Selects the long timer table
  parameter int WAIT_8192          = 8192,  // Wait for code 000
  parameter int WAIT_16384         = 16384, // Wait for code 001
  parameter int WAIT_32768         = 32768, // Variant wait for code 010
  parameter int WAIT_65536         = 65536, // Variant wait for code 011
  parameter int WAIT_131072        = 131072 // Variant wait for code 100
) (
  input  wire logic        hclk,              // System clock, 100 MHz
  input  wire logic        hresetn,           // Async reset, active low
  input  wire logic        hsel,              // Slave select
  input  wire logic [31:0] haddr,             // Address
  input  wire logic [1:0]  htrans,            // Transfer type
  input  wire logic        hwrite,            // Write when high
  input  wire logic [2:0]  hsize,             // Transfer size
  input  wire logic [31:0] hwdata,            // Write data
  input  wire logic        hready,            // Bus ready
  output logic [31:0]      hrdata,            // Read data
  output logic             hreadyout,         // Slave ready
  output logic             hresp,             // Response, always OKAY
  input  wire logic        sleep_exec,        // Sleep instruction executed, pulse
  input  wire logic        wake_irq,          // Interrupt ending low power, pulse
  output logic             enter_sleep,       // Enter sleep or subsleep, pulse
  output logic             enter_standby,     // Enter standby or watch, pulse
  output logic             cpu_run,           // CPU and peripherals released
  output logic             resume_subclock,   // CPU runs on subclock after watch
  output logic [1:0]       medium_div_sel     // Medium speed divider select
);

  pdmc_state_type s_q;
  pdmc_state_type s_d;
  logic           wait_start;
  logic           wait_busy;
  logic           wait_done;
  logic [17:0]    wait_len;
  logic           addr_ok;
  logic           rd_cap;
  logic           wr_cap;

  // Map the standby timer code to a number of states
  // timer code decode
  function automatic logic [17:0] pdmc_wait_states(input logic [2:0] code);
    logic [17:0] n;
    n = `PDMC_WAIT_8;
    case (code)
      `PDMC_STS_8192:   n = 18'(WAIT_8192);
      `PDMC_STS_16384:  n = 18'(WAIT_16384);
      `PDMC_STS_SEL2:   n = ONCHIP_OSC_VARIANT ? 18'(WAIT_32768) : `PDMC_WAIT_1024;
      `PDMC_STS_SEL3:   n = ONCHIP_OSC_VARIANT ? 18'(WAIT_65536) : `PDMC_WAIT_2048;
      `PDMC_STS_SEL4:   n = ONCHIP_OSC_VARIANT ? 18'(WAIT_131072) : `PDMC_WAIT_4096;
      `PDMC_STS_EXTCLK: n = `PDMC_WAIT_2;
      `PDMC_STS_8:      n = `PDMC_WAIT_8;
      `PDMC_STS_16:     n = `PDMC_WAIT_16;
      default:          n = `PDMC_WAIT_8;
    endcase
    return n;
  endfunction

  // Read image of the register, reserved bit forced high
  // reserved bit reads one
  function automatic logic [7:0] pdmc_image(input pdmc_state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[`PDMC_STANDBY_BIT]        = s.standby_sel;
    v[`PDMC_STS_HI:`PDMC_STS_LO] = s.sts;
    v[`PDMC_LOW_SPEED_BIT]      = s.low_speed_sel;
    v[`PDMC_RSV_BIT]            = 1'b1;
    v[`PDMC_MA_HI:`PDMC_MA_LO]  = s.ma;
    return v;
  endfunction

  // Address phase decode; only one word is mapped, others read zero
  assign addr_ok  = (haddr[7:0] == `PDMC_REG_OFFSET);
  assign rd_cap   = hsel && hready && htrans[1] && !hwrite;
  assign wr_cap   = hsel && hready && htrans[1] && hwrite && addr_ok;
  assign wait_len = pdmc_wait_states(s_q.sts);

  // The wait only applies when the oscillator was halted (standby or watch)
  assign wait_start = (s_q.mode == PDMC_LOWPWR) && wake_irq && s_q.lp_deep;

  pdmc_wait_counter u_wait (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (wait_start),
    .length  (wait_len),
    .busy    (wait_busy),
    .done    (wait_done)
  );

  // Next state: bus slave, register file and power sequencing
  always_comb begin
    s_d               = s_q;
    s_d.enter_sleep   = 1'b0;
    s_d.enter_standby = 1'b0;
    s_d.hready        = 1'b1;
    s_d.wr_pend       = wr_cap;
    // Write data phase; reserved bit has no storage so writes cannot touch it
    // timer field store
    if (s_q.wr_pend) begin
      s_d.standby_sel   = hwdata[`PDMC_STANDBY_BIT];
      s_d.sts           = hwdata[`PDMC_STS_HI:`PDMC_STS_LO];
      s_d.low_speed_sel = hwdata[`PDMC_LOW_SPEED_BIT];
      s_d.ma      = hwdata[`PDMC_MA_HI:`PDMC_MA_LO];
      s_d.wr_seen = 1'b1;
    end
    // Read captured from next values so a read right after a write sees it
    if (rd_cap) begin
      s_d.rdata = addr_ok ? pdmc_image(s_d) : 8'h00;
    end
    case (s_q.mode)
      PDMC_ACTIVE: begin
        if (sleep_exec) begin
          s_d.mode          = PDMC_LOWPWR;
          s_d.cpu_run       = 1'b0;
          s_d.lp_deep       = s_q.standby_sel;
          s_d.enter_standby = s_q.standby_sel;
          s_d.enter_sleep   = !s_q.standby_sel;
        end
      end
      PDMC_LOWPWR: begin
        // Sleep keeps the clock running, so resume at once
        if (wake_irq) begin
          s_d.mode       = s_q.lp_deep ? PDMC_WAIT : PDMC_ACTIVE;
          s_d.cpu_run    = !s_q.lp_deep;
          s_d.resume_sub = 1'b0;
        end
      end
      PDMC_WAIT: begin
        if (wait_done) begin
          s_d.mode       = PDMC_ACTIVE;
          s_d.cpu_run    = 1'b1;
          s_d.resume_sub = s_q.low_speed_sel;
        end
      end
      default: begin
        s_d.mode = PDMC_ACTIVE;
      end
    endcase
  end

  // State register; divider bits, hready and cpu_run come out of reset high, others low
  // reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q         <= '0;
      s_q.mode    <= PDMC_ACTIVE;
      s_q.ma      <= `PDMC_MA_RESET;
      s_q.hready  <= 1'b1;
      s_q.cpu_run <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata          = {24'h000000, s_q.rdata};
  assign hreadyout       = s_q.hready;
  assign hresp           = 1'b0;
  assign enter_sleep     = s_q.enter_sleep;
  assign enter_standby   = s_q.enter_standby;
  assign cpu_run         = s_q.cpu_run;
  assign resume_subclock = s_q.resume_sub;
  assign medium_div_sel  = s_q.ma;

  // Checks on the sequencer and the register file
  sequence pdmc_deep_wake(logic [2:0] code);
    (s_q.mode == PDMC_LOWPWR) && wake_irq && s_q.lp_deep && (s_q.sts == code);
  endsequence

  sequence pdmc_held_then_run_8;
    !cpu_run [*8] ##1 cpu_run;
  endsequence

  a_sleep_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.mode == PDMC_ACTIVE) && sleep_exec && !s_q.standby_sel |=> enter_sleep && !enter_standby && !cpu_run)
    else $error("sleep with standby bit low did not enter sleep");

  a_standby_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.mode == PDMC_ACTIVE) && sleep_exec && s_q.standby_sel |=> enter_standby && !enter_sleep)
    else $error("sleep with standby bit high did not enter standby");

  a_timer_field: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.wr_pend |=> s_q.sts == $past(hwdata[6:4]))
    else $error("timer field not stored from write data");

  a_reserved_one: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_cap && addr_ok |=> hrdata[2] && (hrdata[31:8] == 24'h000000))
    else $error("reserved bit did not read one");

  a_reset_image: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_cap && addr_ok && !s_q.wr_seen && !s_q.wr_pend |=> hrdata == 32'h00000007)
    else $error("register read after reset not 0x07");

  a_wait_eight: assert property (@(posedge hclk) disable iff (!hresetn)
    pdmc_deep_wake(3'h6) |=> pdmc_held_then_run_8)
    else $error("eight state wait did not release on time");

  a_wait_extclk: assert property (@(posedge hclk) disable iff (!hresetn)
    pdmc_deep_wake(3'h5) |=> !cpu_run [*2] ##1 cpu_run)
    else $error("two state wait did not release on time");

  a_wait_length: assert property (@(posedge hclk) disable iff (!hresetn)
    wait_start |-> (s_q.sts != 3'h5 || wait_len == 18'h00002) && (s_q.sts != 3'h6 || wait_len == 18'h00008)
      && (s_q.sts != 3'h7 || wait_len == 18'h00010))
    else $error("wait length does not follow timer code");

  a_resume_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(cpu_run) && ($past(s_q.mode) == PDMC_WAIT) |-> resume_subclock == $past(s_q.low_speed_sel))
    else $error("resume clock does not follow low speed bit");

  a_divider_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.wr_pend |=> medium_div_sel == $past(hwdata[1:0]))
    else $error("divider select not stored");

endmodule // pdmc_top

/* File: core/pdmc_wait_counter.sv */
`timescale 1ns/1ps
// Down counter for the clock settling wait; done is high in the cycle the last state is counted
module pdmc_wait_counter
  import pdmc_pkg::*;
(
  input  wire logic        hclk,     // System clock
  input  wire logic        hresetn,  // Async reset, active low
  input  wire logic        start,    // Load pulse
  input  wire logic [17:0] length,   // Number of states to wait
  output logic             busy,     // Counting
  output logic             done      // Last state of the wait
);

  pdmc_cnt_type c_q;
  pdmc_cnt_type c_d;

  // Load on start, then count down to one
  always_comb begin
    c_d = c_q;
    if (start) begin
      c_d.busy = 1'b1;
      c_d.cnt  = length;
    end else if (c_q.busy) begin
      c_d.cnt = c_q.cnt - 18'h00001;
      if (c_q.cnt == 18'h00001) begin
        c_d.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign busy = c_q.busy;
  assign done = c_q.busy && (c_q.cnt == 18'h00001);

endmodule // pdmc_wait_counter

/* File: pkg/pdmc_cfg.svh */
`ifndef PDMC_CFG_SVH
`define PDMC_CFG_SVH

// Register placement inside the slave window (byte address, low byte of haddr)
`define PDMC_REG_OFFSET     8'h00

// Field positions of power_mode_control_one
`define PDMC_STANDBY_BIT    7
`define PDMC_STS_HI         6
`define PDMC_STS_LO         4
`define PDMC_LOW_SPEED_BIT  3
`define PDMC_RSV_BIT        2
`define PDMC_MA_HI          1
`define PDMC_MA_LO          0

// Reset value: all control bits 0, reserved bit and divider bits 1
`define PDMC_RESET_VALUE    8'h07
`define PDMC_MA_RESET       2'h3

// Standby timer encodings
`define PDMC_STS_8192       3'h0
`define PDMC_STS_16384      3'h1
`define PDMC_STS_SEL2       3'h2
`define PDMC_STS_SEL3       3'h3
`define PDMC_STS_SEL4       3'h4
`define PDMC_STS_EXTCLK     3'h5
`define PDMC_STS_8          3'h6
`define PDMC_STS_16         3'h7

// Short wait lengths in states (one state is one hclk cycle)
`define PDMC_WAIT_2         18'h00002
`define PDMC_WAIT_8         18'h00008
`define PDMC_WAIT_16        18'h00010
`define PDMC_WAIT_1024      18'h00400
`define PDMC_WAIT_2048      18'h00800
`define PDMC_WAIT_4096      18'h01000

`endif

/* File: pkg/pdmc_pkg.sv */
package pdmc_pkg;

  // Power state of the sequencer
  typedef enum logic [1:0] {
    PDMC_ACTIVE,
    PDMC_LOWPWR,
    PDMC_WAIT
  } pdmc_mode_type;

  // Wait counter state
  typedef struct packed {
    logic        busy;
    logic [17:0] cnt;
  } pdmc_cnt_type;

  // Top level state
  typedef struct packed {
    pdmc_mode_type mode;
    logic          standby_sel;
    logic [2:0]    sts;
    logic          low_speed_sel;
    logic [1:0]    ma;
    logic          wr_pend;
    logic          wr_seen;
    logic [7:0]    rdata;
    logic          hready;
    logic          lp_deep;
    logic          cpu_run;
    logic          enter_sleep;
    logic          enter_standby;
    logic          resume_sub;
  } pdmc_state_type;

endpackage

/* File: verif/pdmc_top_test.sv */
`timescale 1ns/1ps
`include "pdmc_cfg.svh"
module pdmc_top_test;
  import pdmc_pkg::*;

  // Short counts keep the long waits cheap to run
  localparam int W0 = 20;
  localparam int W1 = 24;
  localparam int WAITS [8] = '{W0, W1, 1024, 2048, 4096, 2, 8, 16};

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sleep_exec;
  logic        wake_irq;
  logic        enter_sleep;
  logic        enter_standby;
  logic        cpu_run;
  logic        resume_subclock;
  logic [1:0]  medium_div_sel;
  logic [31:0] rd;
  logic [31:0] wdat;
  int          failures;
  int          checks;

  pdmc_top #(.WAIT_8192(W0), .WAIT_16384(W1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
    .enter_sleep(enter_sleep), .enter_standby(enter_standby), .cpu_run(cpu_run),
    .resume_subclock(resume_subclock), .medium_div_sel(medium_div_sel)
  );

  // Free running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    // A slave that never answers counts as a mismatch
    if (n >= 100) begin
      check({31'h0, hreadyout}, 32'h1);
    end
  endtask

  // One single-word AHB transfer; read data taken at the data phase edge
  task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  // Sleep pulse, then a second one that must be ignored in low power
  task automatic do_sleep(input logic deep);
    logic first;
    first = 1'b1;
    repeat (2) begin
      @(posedge hclk);
      sleep_exec <= 1'b1;
      @(posedge hclk);
      sleep_exec <= 1'b0;
      #1;
      check({31'h0, enter_standby}, {31'h0, deep & first});
      check({31'h0, enter_sleep}, {31'h0, ~deep & first});
      check({31'h0, cpu_run}, 32'h0);
      first = 1'b0;
    end
  endtask

  // Wake pulse, count cycles until the CPU is released
  task automatic do_wake(input int exp_n, input logic exp_sub);
    int n;
    @(posedge hclk);
    wake_irq <= 1'b1;
    @(posedge hclk);
    wake_irq <= 1'b0;
    #1;
    n = 1;
    while (cpu_run !== 1'b1 && n < 10000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check(n, exp_n);
    check({31'h0, resume_subclock}, {31'h0, exp_sub});
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run of about 7,300 cycles
  initial begin
    #500000;
    failures++;
    finish_test();
  end

  initial begin
    failures   = 0;
    checks     = 0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    sleep_exec = 1'b0;
    wake_irq   = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values
    ahb_xfer(1'b0, `PDMC_REG_OFFSET, 32'h0, rd);
    check(rd, 32'h07);
    check({30'h0, medium_div_sel}, 32'h3);
    check({31'h0, cpu_run}, 32'h1);
    check({31'h0, hreadyout}, 32'h1);
    // Reserved bit stays 1 whatever is written
    ahb_xfer(1'b1, `PDMC_REG_OFFSET, 32'hfb, rd);
    ahb_xfer(1'b0, `PDMC_REG_OFFSET, 32'h0, rd);
    check(rd, 32'hff);
    ahb_xfer(1'b1, `PDMC_REG_OFFSET, 32'h02, rd);
    ahb_xfer(1'b0, `PDMC_REG_OFFSET, 32'h0, rd);
    check(rd, 32'h06);
    check({30'h0, medium_div_sel}, 32'h2);
    // Unmapped address reads zero and ignores writes
    ahb_xfer(1'b1, 32'h10, 32'hff, rd);
    ahb_xfer(1'b0, 32'h10, 32'h0, rd);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // Plain sleep: released one cycle after the interrupt
    do_sleep(1'b0);
    do_wake(1, 1'b0);
    // Deep sleep for every timer code, resume clock alternating
    // timer sweep, software choice
    for (int c = 0; c < 8; c++) begin
      wdat = {24'h0, 1'b1, c[2:0], c[0], 3'b001};
      ahb_xfer(1'b1, `PDMC_REG_OFFSET, wdat, rd);
      ahb_xfer(1'b0, `PDMC_REG_OFFSET, 32'h0, rd);
      check(rd, wdat | 32'h4);
      check({30'h0, medium_div_sel}, 32'h1);
      do_sleep(1'b1);
      do_wake(WAITS[c] + 1, c[0]);
    end
    finish_test();
  end
endmodule // pdmc_top_test
